// ==== core/cfr_pkg.sv ====
// Purpose: shared types and constants of the card file command block
// Assumes: one elementary_file is configured at a time through the register port
// Notes: record numbers and counts are eight bits wide
package cfr_pkg;
	// command kinds
	typedef enum logic [1:0] {
		CFR_OP_RD_BIN  = 2'h0,
		CFR_OP_UPD_BIN = 2'h1,
		CFR_OP_RD_REC  = 2'h2,
		CFR_OP_UPD_REC = 2'h3
	} cfr_op_t;
	// file structure
	typedef enum logic [1:0] {
		CFR_FS_TRANSP = 2'h0,
		CFR_FS_LINEAR = 2'h1,
		CFR_FS_CYCLIC = 2'h2
	} cfr_fs_t;
	// answer codes
	typedef enum logic [2:0] {
		CFR_ST_OK        = 3'h0,
		CFR_ST_DENIED    = 3'h1,
		CFR_ST_NO_DATA   = 3'h2,
		CFR_ST_BAD_PARAM = 3'h3,
		CFR_ST_NOT_FOUND = 3'h4,
		CFR_ST_WRONG_LEN = 3'h5
	} cfr_status_t;
	// sequencer states
	typedef enum logic [3:0] {
		CFR_S_IDLE  = 4'h1,
		CFR_S_READ  = 4'h2,
		CFR_S_WRITE = 4'h4,
		CFR_S_DONE  = 4'h8
	} cfr_state_t;
	// one command header
	typedef struct packed {
		cfr_op_t    op;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] len;
	} cfr_cmd_t;
	// record selection result
	typedef struct packed {
		logic       bad_mode;
		logic       fail;
		logic       move;
		logic       rotate;
		logic [7:0] target;
		logic [7:0] new_ptr;
	} cfr_recsel_t;
	// parameter byte fields
	localparam int         P1_OFS_FLAG = 7;
	localparam int         P1_OFS_HI   = 6;
	localparam int         P1_SFI_LO   = 5;
	localparam int         SFI_MSB     = 4;
	localparam int         P2_SFI_MSB  = 7;
	localparam int         P2_SFI_LSB  = 3;
	localparam int         P2_MODE_MSB = 2;
	localparam logic [2:0] P1_SFI_CODE = 3'h4;
	localparam logic [2:0] MODE_NEXT   = 3'h2;
	localparam logic [2:0] MODE_PREV   = 3'h3;
	localparam logic [2:0] MODE_ABS    = 3'h4;
	localparam logic [4:0] SFI_NONE    = 5'h00;
	localparam logic [4:0] SFI_MAX     = 5'h1E;
	localparam logic [7:0] REC_CURRENT = 8'h00;
	localparam logic [7:0] REC_FIRST   = 8'h01;
	localparam logic [8:0] BIN_LEN_MAX = 9'h100;
	// register map and fields
	localparam logic [3:0]  REG_CFG      = 4'h0;
	localparam logic [3:0]  REG_RECLEN   = 4'h1;
	localparam logic [3:0]  REG_RECCNT   = 4'h2;
	localparam logic [3:0]  REG_STATUS   = 4'h3;
	localparam logic [3:0]  REG_CTRL     = 4'h4;
	localparam int          CFG_FS_MSB   = 1;
	localparam int          CFG_RD_AC    = 2;
	localparam int          CFG_UPD_AC   = 3;
	localparam int          CFG_SFI_LSB  = 4;
	localparam int          CTRL_PTR_CLR = 0;
	localparam logic [15:0] CFG_RESET    = 16'h0000;
	localparam logic [7:0]  RECLEN_RESET = 8'h00;
	localparam logic [7:0]  RECCNT_RESET = 8'h00;
endpackage

// ==== core/cfr_mem.sv ====
// Purpose: byte store that holds the contents of the elementary_file
// Assumes: one write port and one read port on the same clock
// Notes: read data come out of a register one cycle after the request
`timescale 1ns/100ps
module cfr_mem #(
	parameter int AW = 12,
	parameter int DW = 8
) (
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	// write port
	input  wire logic          we_in,
	input  wire logic [AW-1:0] waddr_in,
	input  wire logic [DW-1:0] wdata_in,
	// read port
	input  wire logic          re_in,
	input  wire logic [AW-1:0] raddr_in,
	output logic      [DW-1:0] rdata_out
);
	logic [DW-1:0] mem_q [2**AW];
	logic [DW-1:0] rdata_q;

	// storage array, no reset
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem_q[waddr_in] <= wdata_in;
		end
	end

	// registered read port
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= '0;
		end else if (re_in) begin
			rdata_q <= mem_q[raddr_in];
		end
	end

	assign rdata_out = rdata_q;
endmodule

// ==== core/cfr_recsel.sv ====
// Purpose: picks the target record and the new record pointer
// Assumes: pointer and targets are logical record numbers starting at one
// Notes: purely combinational; the caller commits the pointer only on success
`timescale 1ns/100ps
module cfr_recsel (
	// command fields
	input  wire logic [2:0]           mode_in,
	input  wire logic [7:0]           p1_in,
	input  wire logic                 is_wr_in,
	// file state
	input  wire logic [7:0]           ptr_in,
	input  wire logic                 ptr_set_in,
	input  wire logic [7:0]           cnt_in,
	input  wire logic                 cyclic_in,
	// decision
	output cfr_pkg::cfr_recsel_t      res_out
);
	wire logic at_last  = ptr_in >= cnt_in;
	wire logic at_first = ptr_in <= cfr_pkg::REC_FIRST;
	wire logic cyc_wr   = cyclic_in && is_wr_in;

	// mode decode; p1 is not looked at in next and previous modes
	always_comb begin
		res_out = '0;
		case (mode_in)
			cfr_pkg::MODE_ABS: begin
				res_out.bad_mode = cyc_wr;
				if (p1_in == cfr_pkg::REC_CURRENT) begin
					res_out.target = ptr_in;
					res_out.fail   = !ptr_set_in;
				end else begin
					res_out.target = p1_in;
					res_out.fail   = p1_in > cnt_in;
				end
			end
			cfr_pkg::MODE_NEXT: begin
				res_out.bad_mode = cyc_wr;
				res_out.move     = 1'b1;
				if (!ptr_set_in) begin
					res_out.target = cfr_pkg::REC_FIRST;
				end else if (!at_last) begin
					res_out.target = ptr_in + cfr_pkg::REC_FIRST;
				end else if (cyclic_in) begin
					res_out.target = cfr_pkg::REC_FIRST;
				end else begin
					res_out.fail = 1'b1;
				end
			end
			cfr_pkg::MODE_PREV: begin
				res_out.move = 1'b1;
				if (cyc_wr) begin
					res_out.target = cnt_in;
					res_out.rotate = 1'b1;
				end else if (!ptr_set_in) begin
					res_out.target = cnt_in;
				end else if (!at_first) begin
					res_out.target = ptr_in - cfr_pkg::REC_FIRST;
				end else if (cyclic_in) begin
					res_out.target = cnt_in;
				end else begin
					res_out.fail = 1'b1;
				end
			end
			default: begin
				res_out.bad_mode = 1'b1;
			end
		endcase
		if (cnt_in == cfr_pkg::REC_CURRENT) begin
			res_out.fail = 1'b1;
		end
		res_out.new_ptr = res_out.rotate ? cfr_pkg::REC_FIRST : res_out.target;
	end
endmodule

// ==== core/cfr_card_files.sv ====
// Purpose: interprets byte and record read and write commands on one file
// Assumes: the terminal side sends decoded command headers and data bytes
// Notes: access conditions and file selection come from configuration bits
`timescale 1ns/100ps
module cfr_card_files #(
	parameter int MEM_AW = 12 // file holds 2**MEM_AW bytes, at most 15 (offset width)
) (
	// clock and reset
	input  wire logic                  core_clk_in,
	input  wire logic                  arst_n_in,
	// command header
	input  wire logic                  cmd_valid_in,
	input  wire cfr_pkg::cfr_cmd_t     cmd_in,
	output logic                       cmd_ready_out,
	// data bytes into the file
	input  wire logic                  wr_valid_in,
	input  wire logic [7:0]            wr_data_in,
	output logic                       wr_ready_out,
	// data bytes out of the file
	output logic                       rd_valid_out,
	output logic      [7:0]            rd_data_out,
	// command answer
	output logic                       rsp_valid_out,
	output cfr_pkg::cfr_status_t       rsp_status_out,
	// register port
	input  wire logic [3:0]            reg_addr_in,
	input  wire logic [15:0]           reg_wdata_in,
	input  wire logic                  reg_wr_in,
	input  wire logic                  reg_rd_in,
	output logic      [15:0]           reg_rdata_out
);
	localparam logic [15:0] MEM_BYTES = 16'(1 << MEM_AW);

	logic                 rst_sync_q;
	logic                 rst_n_q;
	logic [15:0]          cfg_q;
	logic [7:0]           reclen_q;
	logic [7:0]           reccnt_q;
	logic [7:0]           ptr_q;
	logic                 ptr_set_q;
	logic [7:0]           head_q;
	cfr_pkg::cfr_state_t  state_q;
	cfr_pkg::cfr_state_t  state_d;
	cfr_pkg::cfr_status_t status_q;
	logic [MEM_AW-1:0]    base_q;
	logic [8:0]           idx_q;
	logic [8:0]           len_q;
	logic                 rd_valid_q;
	logic [15:0]          reg_rdata_q;
	cfr_pkg::cfr_recsel_t rs;

	// maps a logical record number onto its storage slot
	function automatic logic [7:0] phys_slot(input logic [7:0] n,
		input logic [7:0] head, input logic [7:0] cnt);
		logic [8:0] p;
		p = {1'b0, head} + {1'b0, n} - {1'b0, cfr_pkg::REC_FIRST};
		if (p >= {1'b0, cnt}) begin
			p = p - {1'b0, cnt};
		end
		return p[7:0];
	endfunction

	// reset release through two flops
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_sync_q <= 1'b1;
			rst_n_q    <= rst_sync_q;
		end
	end

	// configuration fields
	wire cfr_pkg::cfr_fs_t fs = cfr_pkg::cfr_fs_t'(cfg_q[cfr_pkg::CFG_FS_MSB:0]);
	wire logic cyclic  = fs == cfr_pkg::CFR_FS_CYCLIC;
	wire logic rd_ac   = cfg_q[cfr_pkg::CFG_RD_AC];
	wire logic upd_ac  = cfg_q[cfr_pkg::CFG_UPD_AC];
	wire logic [4:0] cfg_sfi =
		cfg_q[cfr_pkg::CFG_SFI_LSB+cfr_pkg::SFI_MSB:cfr_pkg::CFG_SFI_LSB];

	// register port decode
	wire logic cfg_wr  = reg_wr_in && reg_addr_in == cfr_pkg::REG_CFG;
	wire logic ctrl_wr = reg_wr_in && reg_addr_in == cfr_pkg::REG_CTRL;
	wire logic ptr_clr = cfg_wr || (ctrl_wr && reg_wdata_in[cfr_pkg::CTRL_PTR_CLR]);
	wire logic busy    = state_q != cfr_pkg::CFR_S_IDLE;
	wire logic [15:0] reg_mux =
		(reg_addr_in == cfr_pkg::REG_CFG)    ? cfg_q :
		(reg_addr_in == cfr_pkg::REG_RECLEN) ? {8'h00, reclen_q} :
		(reg_addr_in == cfr_pkg::REG_RECCNT) ? {8'h00, reccnt_q} :
		(reg_addr_in == cfr_pkg::REG_STATUS) ? {6'h00, busy, ptr_set_q, ptr_q} :
		16'h0000; // unmapped and control read as zero

	// command kind decode
	wire logic accept = cmd_valid_in && state_q == cfr_pkg::CFR_S_IDLE;
	wire logic is_bin = cmd_in.op == cfr_pkg::CFR_OP_RD_BIN ||
		cmd_in.op == cfr_pkg::CFR_OP_UPD_BIN;
	wire logic is_wr  = cmd_in.op == cfr_pkg::CFR_OP_UPD_BIN ||
		cmd_in.op == cfr_pkg::CFR_OP_UPD_REC;
	wire logic [2:0] rec_mode = cmd_in.p2[cfr_pkg::P2_MODE_MSB:0];

	// byte offset decode, shared by byte read and byte write
	wire logic bin_plain = !cmd_in.p1[cfr_pkg::P1_OFS_FLAG];
	wire logic bin_sfi   =
		cmd_in.p1[cfr_pkg::P1_OFS_FLAG:cfr_pkg::P1_SFI_LO] == cfr_pkg::P1_SFI_CODE;
	wire logic [14:0] bin_off = bin_plain ?
		{cmd_in.p1[cfr_pkg::P1_OFS_HI:0], cmd_in.p2} : {7'h00, cmd_in.p2};
	wire logic [8:0] bin_len = (cmd_in.len == 8'h00) ?
		cfr_pkg::BIN_LEN_MAX : {1'b0, cmd_in.len};
	wire logic [15:0] bin_end = {1'b0, bin_off} + {7'h00, bin_len};

	// file selection: short_file_ident or current file
	wire logic [4:0] rec_sfi = cmd_in.p2[cfr_pkg::P2_SFI_MSB:cfr_pkg::P2_SFI_LSB];
	wire logic [4:0] sfi_req = is_bin ? cmd_in.p1[cfr_pkg::SFI_MSB:0] : rec_sfi;
	wire logic sfi_used = is_bin ? bin_sfi : rec_sfi != cfr_pkg::SFI_NONE;
	wire logic file_ok  = !sfi_used || sfi_req == cfg_sfi;
	wire logic struct_ok = is_bin == (fs == cfr_pkg::CFR_FS_TRANSP);

	// record target and pointer movement
	cfr_recsel u_recsel (
		.mode_in    (rec_mode),
		.p1_in      (cmd_in.p1),
		.is_wr_in   (is_wr),
		.ptr_in     (ptr_q),
		.ptr_set_in (ptr_set_q),
		.cnt_in     (reccnt_q),
		.cyclic_in  (cyclic),
		.res_out    (rs)
	);

	// record slot and start address; linear files keep slot order fixed
	wire logic [7:0] head_eff = cyclic ? head_q : 8'h00;
	wire logic [7:0] rec_slot = phys_slot(rs.target, head_eff, reccnt_q);
	wire logic [15:0] rec_prod = rec_slot * reclen_q;

	// checks in priority order
	wire logic param_bad = is_bin ? !(bin_plain || bin_sfi) :
		(rec_sfi > cfr_pkg::SFI_MAX || rs.bad_mode);
	wire logic ac_ok = is_wr ? upd_ac : rd_ac;
	wire logic len_bad = !is_bin && (is_wr ? cmd_in.len != reclen_q :
		(cmd_in.len != 8'h00 && cmd_in.len != reclen_q));
	wire logic no_data = is_bin ? bin_end > MEM_BYTES :
		(rs.fail || reclen_q == 8'h00);
	wire cfr_pkg::cfr_status_t cmd_status =
		param_bad               ? cfr_pkg::CFR_ST_BAD_PARAM :
		!(file_ok && struct_ok) ? cfr_pkg::CFR_ST_NOT_FOUND :
		!ac_ok                  ? cfr_pkg::CFR_ST_DENIED :
		len_bad                 ? cfr_pkg::CFR_ST_WRONG_LEN :
		no_data                 ? cfr_pkg::CFR_ST_NO_DATA :
		cfr_pkg::CFR_ST_OK;
	wire logic cmd_ok = cmd_status == cfr_pkg::CFR_ST_OK;
	wire logic acc_ok = accept && cmd_ok;
	wire logic upd_ptr = acc_ok && !is_bin && rs.move;

	// transfer stepping
	wire logic xfer_last = (idx_q + 9'h001) == len_q;
	wire logic mem_re    = state_q == cfr_pkg::CFR_S_READ;
	wire logic mem_we    = state_q == cfr_pkg::CFR_S_WRITE && wr_valid_in;
	wire logic [MEM_AW-1:0] addr_cur = base_q + MEM_AW'(idx_q);

	// sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			cfr_pkg::CFR_S_IDLE: begin
				if (accept && !cmd_ok) begin
					state_d = cfr_pkg::CFR_S_DONE;
				end else if (accept) begin
					state_d = is_wr ? cfr_pkg::CFR_S_WRITE : cfr_pkg::CFR_S_READ;
				end
			end
			cfr_pkg::CFR_S_READ: begin
				if (xfer_last) begin
					state_d = cfr_pkg::CFR_S_DONE;
				end
			end
			cfr_pkg::CFR_S_WRITE: begin
				if (mem_we && xfer_last) begin
					state_d = cfr_pkg::CFR_S_DONE;
				end
			end
			cfr_pkg::CFR_S_DONE: begin
				state_d = cfr_pkg::CFR_S_IDLE;
			end
		endcase
	end

	// state, answer code and transfer bounds
	always_ff @(posedge core_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q  <= cfr_pkg::CFR_S_IDLE;
			status_q <= cfr_pkg::CFR_ST_OK;
			base_q   <= '0;
			len_q    <= 9'h000;
		end else begin
			state_q <= state_d;
			if (accept) begin
				status_q <= cmd_status;
				base_q   <= is_bin ? bin_off[MEM_AW-1:0] : rec_prod[MEM_AW-1:0];
				len_q    <= is_bin ? bin_len : {1'b0, reclen_q};
			end
		end
	end

	// byte index within the transfer
	always_ff @(posedge core_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			idx_q <= 9'h000;
		end else if (accept) begin
			idx_q <= 9'h000;
		end else if (mem_re || mem_we) begin
			idx_q <= idx_q + 9'h001;
		end
	end

	// record pointer and cyclic order; a command update beats a clear
	always_ff @(posedge core_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ptr_q     <= cfr_pkg::REC_CURRENT;
			ptr_set_q <= 1'b0;
			head_q    <= 8'h00;
		end else begin
			if (ptr_clr) begin
				ptr_q     <= cfr_pkg::REC_CURRENT;
				ptr_set_q <= 1'b0;
			end
			if (cfg_wr) begin
				head_q <= 8'h00;
			end
			if (upd_ptr) begin
				ptr_q     <= rs.new_ptr;
				ptr_set_q <= 1'b1;
			end
			if (acc_ok && rs.rotate) begin
				head_q <= rec_slot;
			end
		end
	end

	// configuration registers and registered read data
	always_ff @(posedge core_clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cfg_q       <= cfr_pkg::CFG_RESET;
			reclen_q    <= cfr_pkg::RECLEN_RESET;
			reccnt_q    <= cfr_pkg::RECCNT_RESET;
			reg_rdata_q <= 16'h0000;
			rd_valid_q  <= 1'b0;
		end else begin
			if (cfg_wr) begin
				cfg_q <= reg_wdata_in;
			end
			if (reg_wr_in && reg_addr_in == cfr_pkg::REG_RECLEN) begin
				reclen_q <= reg_wdata_in[7:0];
			end
			if (reg_wr_in && reg_addr_in == cfr_pkg::REG_RECCNT) begin
				reccnt_q <= reg_wdata_in[7:0];
			end
			reg_rdata_q <= reg_rd_in ? reg_mux : 16'h0000;
			rd_valid_q  <= mem_re;
		end
	end

	// file contents
	cfr_mem #(
		.AW (MEM_AW),
		.DW (8)
	) u_mem (
		.clk_in    (core_clk_in),
		.rst_n_in  (rst_n_q),
		.we_in     (mem_we),
		.waddr_in  (addr_cur),
		.wdata_in  (wr_data_in),
		.re_in     (mem_re),
		.raddr_in  (addr_cur),
		.rdata_out (rd_data_out)
	);

	// outputs
	assign cmd_ready_out  = state_q == cfr_pkg::CFR_S_IDLE;
	assign wr_ready_out   = state_q == cfr_pkg::CFR_S_WRITE;
	assign rd_valid_out   = rd_valid_q;
	assign rsp_valid_out  = state_q == cfr_pkg::CFR_S_DONE;
	assign rsp_status_out = status_q;
	assign reg_rdata_out  = reg_rdata_q;

	// checks
	cfr_pkg::cfr_cmd_t last_cmd_q;
	always_ff @(posedge core_clk_in) begin
		last_cmd_q <= cmd_in;
	end
	wire logic rec_cmd = accept && !is_bin && !ptr_clr;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_q);

	property p_bin_read;
		acc_ok && is_bin && !is_wr |=> mem_re ##1 rd_valid_out;
	endproperty
	a_bin_read: assert property (p_bin_read) else $error("byte read sent no data");
	property p_plain_off;
		acc_ok && is_bin && bin_plain |=>
			base_q == MEM_AW'({last_cmd_q.p1[cfr_pkg::P1_OFS_HI:0], last_cmd_q.p2});
	endproperty
	a_plain_off: assert property (p_plain_off) else $error("bad long offset");
	property p_sfi_off;
		acc_ok && is_bin && bin_sfi |=> base_q == MEM_AW'(last_cmd_q.p2);
	endproperty
	a_sfi_off: assert property (p_sfi_off) else $error("bad short offset");
	property p_upd_denied;
		accept && is_bin && is_wr && !upd_ac |=> !wr_ready_out [*2];
	endproperty
	a_upd_denied: assert property (p_upd_denied) else $error("write without access");
	property p_fail_keep;
		rec_cmd && !cmd_ok |=> $stable(ptr_q) && $stable(ptr_set_q);
	endproperty
	a_fail_keep: assert property (p_fail_keep) else $error("failed command moved pointer");
	property p_abs_keep;
		rec_cmd && rec_mode == cfr_pkg::MODE_ABS |=> $stable(ptr_q);
	endproperty
	a_abs_keep: assert property (p_abs_keep) else $error("absolute mode moved pointer");
	property p_next_unset;
		rec_cmd && cmd_ok && rec_mode == cfr_pkg::MODE_NEXT && !ptr_set_q |=>
			ptr_q == cfr_pkg::REC_FIRST && ptr_set_q;
	endproperty
	a_next_unset: assert property (p_next_unset) else $error("next from unset wrong");
	property p_lin_end;
		rec_cmd && fs == cfr_pkg::CFR_FS_LINEAR && rec_mode == cfr_pkg::MODE_NEXT &&
			ptr_set_q && ptr_q == reccnt_q |=>
			status_q != cfr_pkg::CFR_ST_OK && !wr_ready_out && !mem_re;
	endproperty
	a_lin_end: assert property (p_lin_end) else $error("next past last record");
	property p_cyc_wrap;
		rec_cmd && cmd_ok && cyclic && rec_mode == cfr_pkg::MODE_NEXT &&
			ptr_set_q && ptr_q == reccnt_q |=> ptr_q == cfr_pkg::REC_FIRST;
	endproperty
	a_cyc_wrap: assert property (p_cyc_wrap) else $error("cyclic next did not wrap");
	property p_cyc_back;
		rec_cmd && cmd_ok && !is_wr && cyclic && rec_mode == cfr_pkg::MODE_PREV &&
			ptr_set_q && ptr_q == cfr_pkg::REC_FIRST |=> ptr_q == $past(reccnt_q);
	endproperty
	a_cyc_back: assert property (p_cyc_back) else $error("cyclic previous did not wrap");
	property p_cyc_mode;
		accept && cyclic && cmd_in.op == cfr_pkg::CFR_OP_UPD_REC &&
			rec_mode != cfr_pkg::MODE_PREV |=> ##[0:1] rsp_valid_out && status_q != 3'h0;
	endproperty
	a_cyc_mode: assert property (p_cyc_mode) else $error("cyclic write mode taken");
	property p_cyc_upd;
		rec_cmd && cmd_ok && cyclic && is_wr |=>
			ptr_q == cfr_pkg::REC_FIRST && head_q == $past(rec_slot);
	endproperty
	a_cyc_upd: assert property (p_cyc_upd) else $error("cyclic write order wrong");

	c_bin_read: cover property (acc_ok && cmd_in.op == cfr_pkg::CFR_OP_RD_BIN);
	c_cyc_upd: cover property (acc_ok && cyclic && cmd_in.op == cfr_pkg::CFR_OP_UPD_REC);
	c_rec_fail: cover property (accept && !is_bin && rs.fail);
endmodule

// ==== sim/cfr_term.sv ====
// Purpose: terminal model that sends command headers and data bytes
// Assumes: one command at a time, next one after the answer
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/100ps
module cfr_term (
	// clock
	input  wire logic                 clk_in,
	// command header
	output logic                      cmd_valid_out,
	output cfr_pkg::cfr_cmd_t         cmd_out,
	input  wire logic                 cmd_ready_in,
	// data to the card
	output logic                      wr_valid_out,
	output logic [7:0]                wr_data_out,
	input  wire logic                 wr_ready_in,
	// data and answer from the card
	input  wire logic                 rd_valid_in,
	input  wire logic [7:0]           rd_data_in,
	input  wire logic                 rsp_valid_in,
	input  wire cfr_pkg::cfr_status_t rsp_status_in
);
	logic [7:0] rx [0:255];
	int         nrx;
	logic [2:0] st;
	initial begin
		cmd_valid_out = 1'b0;
		cmd_out = '0;
		wr_valid_out = 1'b0;
		wr_data_out = 8'h00;
	end
	// one command: header, data bytes, collect read bytes until the answer
	task automatic xfer(input logic [1:0] op, input logic [7:0] p1, p2, ln, sd);
		int i;
		logic [7:0] p1x;
		i = 0;
		nrx = 0;
		st = 3'h7; // no answer yet: a lost answer shows up as a status mismatch
		p1x = (op[1] && p2[2:1] == 2'h1) ? 8'h00 : p1;
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_out <= {op, p1x, p2, ln};
		do @(posedge clk_in); while (cmd_ready_in !== 1'b1);
		cmd_valid_out <= 1'b0;
		cmd_out <= ~cmd_out;
		if (op[0]) begin
			wr_valid_out <= 1'b1;
			wr_data_out <= sd;
		end
		for (int k = 0; k < 600; k++) begin
			@(posedge clk_in);
			if (rd_valid_in === 1'b1) begin
				rx[nrx] = rd_data_in;
				nrx++;
			end
			if (wr_valid_out && wr_ready_in === 1'b1) begin
				i++;
				wr_data_out <= sd + 8'(i);
				if (i == ((ln == 8'h00) ? 256 : int'(ln)))
					wr_valid_out <= 1'b0;
			end
			if (rsp_valid_in === 1'b1) begin
				st = rsp_status_in;
				break;
			end
		end
		wr_valid_out <= 1'b0;
		wr_data_out <= ~wr_data_out;
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the card file command block
// Assumes: commands come from the terminal model
// Notes: pointer state is read back through the status register
`timescale 1ns/100ps
module tb_top;
	logic                 core_clk_in  = 1'b0;
	logic                 arst_n_in    = 1'b0;
	logic [3:0]           reg_addr_in  = 4'h0;
	logic [15:0]          reg_wdata_in = 16'h0000;
	logic                 reg_wr_in    = 1'b0;
	logic                 reg_rd_in    = 1'b0;
	logic [15:0]          reg_rdata;
	logic                 cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rsp_valid;
	logic [7:0]           wr_data, rd_data;
	cfr_pkg::cfr_cmd_t    cmd;
	cfr_pkg::cfr_status_t rsp_status;
	int                   error_cnt = 0;
	int                   n_tests   = 0;
	// 200 MHz clock
	always #2.5 core_clk_in = ~core_clk_in;
	cfr_card_files u_dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
		.wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_ready_out(wr_ready),
		.rd_valid_out(rd_valid), .rd_data_out(rd_data), .rsp_valid_out(rsp_valid),
		.rsp_status_out(rsp_status), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata));
	cfr_term u_term (.clk_in(core_clk_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
		.cmd_ready_in(cmd_ready), .wr_valid_out(wr_valid), .wr_data_out(wr_data),
		.wr_ready_in(wr_ready), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
		.rsp_valid_in(rsp_valid), .rsp_status_in(rsp_status));
	task automatic chk(input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rw(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rr(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge core_clk_in); // read data stand only in this cycle
		chk(reg_rdata, exp);
	endtask
	// one command: answer code, byte count, first and last byte
	task automatic go(input logic [1:0] op, input logic [7:0] p1, p2, ln, sd,
		input logic [2:0] es, input logic [7:0] eb);
		int n;
		u_term.xfer(op, p1, p2, ln, sd);
		n = (es == 3'h0 && !op[0]) ? int'(ln) : 0;
		chk({13'h0000, u_term.st}, {13'h0000, es});
		chk(16'(u_term.nrx), 16'(n));
		if (n > 0) begin
			chk({8'h00, u_term.rx[0]}, {8'h00, eb});
			chk({8'h00, u_term.rx[n-1]}, {8'h00, eb + 8'(n - 1)});
		end
	endtask
	task automatic t_bin;
		rw(cfr_pkg::REG_CFG, 16'h005C);
		go(2'h1, 8'h01, 8'h02, 8'h03, 8'hA0, 3'h0, 8'h00);
		go(2'h0, 8'h01, 8'h02, 8'h03, 8'h00, 3'h0, 8'hA0);
		go(2'h1, 8'h85, 8'h10, 8'h02, 8'hC0, 3'h0, 8'h00);
		go(2'h0, 8'h00, 8'h10, 8'h02, 8'h00, 3'h0, 8'hC0);
		go(2'h0, 8'h86, 8'h10, 8'h02, 8'h00, 3'h4, 8'h00);
		rw(cfr_pkg::REG_CFG, 16'h0058);
		go(2'h0, 8'h00, 8'h10, 8'h02, 8'h00, 3'h1, 8'h00);
		rw(cfr_pkg::REG_CFG, 16'h0054);
		go(2'h1, 8'h00, 8'h10, 8'h02, 8'hEE, 3'h1, 8'h00);
		go(2'h0, 8'h00, 8'h10, 8'h02, 8'h00, 3'h0, 8'hC0);
		$display("done byte commands");
	endtask
	task automatic t_lin;
		rr(cfr_pkg::REG_RECLEN, 16'h0000);
		rw(cfr_pkg::REG_CFG, 16'h005D);
		rw(cfr_pkg::REG_RECLEN, 16'h0002);
		rw(cfr_pkg::REG_RECCNT, 16'h0003);
		for (int r = 1; r < 4; r++)
			go(2'h3, 8'(r), 8'h04, 8'h02, 8'(r * 16), 3'h0, 8'h00);
		go(2'h2, 8'h00, 8'h02, 8'h02, 8'h00, 3'h0, 8'h10);
		rr(cfr_pkg::REG_STATUS, 16'h0101);
		go(2'h2, 8'h00, 8'h02, 8'h02, 8'h00, 3'h0, 8'h20);
		go(2'h2, 8'h00, 8'h02, 8'h02, 8'h00, 3'h0, 8'h30);
		go(2'h3, 8'h00, 8'h02, 8'h02, 8'h55, 3'h2, 8'h00);
		go(2'h2, 8'h00, 8'h02, 8'h02, 8'h00, 3'h2, 8'h00);
		rr(cfr_pkg::REG_STATUS, 16'h0103);
		go(2'h2, 8'h00, 8'h03, 8'h02, 8'h00, 3'h0, 8'h20);
		go(2'h2, 8'h00, 8'h03, 8'h02, 8'h00, 3'h0, 8'h10);
		go(2'h2, 8'h00, 8'h03, 8'h02, 8'h00, 3'h2, 8'h00);
		go(2'h2, 8'h03, 8'h04, 8'h02, 8'h00, 3'h0, 8'h30);
		go(2'h2, 8'h00, 8'h04, 8'h02, 8'h00, 3'h0, 8'h10);
		rr(cfr_pkg::REG_STATUS, 16'h0101);
		go(2'h2, 8'h01, 8'h07, 8'h02, 8'h00, 3'h3, 8'h00);
		go(2'h2, 8'h01, 8'hFC, 8'h02, 8'h00, 3'h3, 8'h00);
		go(2'h2, 8'h01, 8'h2C, 8'h02, 8'h00, 3'h0, 8'h10);
		go(2'h3, 8'h00, 8'h02, 8'h02, 8'h77, 3'h0, 8'h00);
		go(2'h2, 8'h02, 8'h04, 8'h02, 8'h00, 3'h0, 8'h77);
		rw(cfr_pkg::REG_CFG, 16'h0055);
		go(2'h3, 8'h01, 8'h04, 8'h02, 8'h66, 3'h1, 8'h00);
		go(2'h2, 8'h00, 8'h03, 8'h02, 8'h00, 3'h0, 8'h30);
		rr(cfr_pkg::REG_STATUS, 16'h0103);
		rw(cfr_pkg::REG_CFG, 16'h005D);
		go(2'h3, 8'h00, 8'h03, 8'h02, 8'h99, 3'h0, 8'h00);
		go(2'h2, 8'h03, 8'h04, 8'h02, 8'h00, 3'h0, 8'h99);
		$display("done linear records");
	endtask
	task automatic t_cyc;
		rw(cfr_pkg::REG_CFG, 16'h005E);
		rw(cfr_pkg::REG_RECLEN, 16'h0001);
		for (int r = 0; r < 3; r++)
			go(2'h3, 8'h00, 8'h03, 8'h01, 8'(8'hA0 + r), 3'h0, 8'h00);
		rr(cfr_pkg::REG_STATUS, 16'h0101);
		for (int r = 1; r < 4; r++)
			go(2'h2, 8'(r), 8'h04, 8'h01, 8'h00, 3'h0, 8'(8'hA3 - r));
		go(2'h3, 8'h01, 8'h04, 8'h01, 8'h11, 3'h3, 8'h00);
		go(2'h3, 8'h00, 8'h02, 8'h01, 8'h11, 3'h3, 8'h00);
		go(2'h2, 8'h00, 8'h03, 8'h01, 8'h00, 3'h0, 8'hA0);
		rr(cfr_pkg::REG_STATUS, 16'h0103);
		go(2'h2, 8'h00, 8'h02, 8'h01, 8'h00, 3'h0, 8'hA2);
		rr(cfr_pkg::REG_STATUS, 16'h0101);
		rw(cfr_pkg::REG_CTRL, 16'h0001);
		rr(cfr_pkg::REG_STATUS, 16'h0000);
		$display("done cyclic records");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		rr(cfr_pkg::REG_STATUS, 16'h0000);
		rw(4'hF, 16'hFFFF);
		rr(4'hF, 16'h0000);
		rr(cfr_pkg::REG_CTRL, 16'h0000);
		t_bin;
		t_lin;
		t_cyc;
		final_report;
	end
	// watchdog well beyond the expected run
	initial begin
		#100000;
		error_cnt++;
		final_report;
	end
endmodule
